// >>> dv/reset_host.sv
`timescale 1ns/1ns
module reset_host (
    input  wire logic i_clk_sys,
    output logic      o_hw_reset_in_n
);
    initial o_hw_reset_in_n = 1'b1;

    // The pin moves 1 ns after an edge so the synchroniser never races the driver.
    task automatic pulse(input int unsigned low_cyc, input int unsigned gap_cyc);
        @(posedge i_clk_sys);
        #1 o_hw_reset_in_n = 1'b0;
        repeat (low_cyc) @(posedge i_clk_sys);
        #1 o_hw_reset_in_n = 1'b1;
        repeat (gap_cyc) @(posedge i_clk_sys);
    endtask
endmodule

// >>> dv/rst_seq_props.sv
`timescale 1ns/1ns
module rst_seq_props
    import rst_seq_pkg::*;
#(
    parameter int unsigned CANCEL_STANDBY = 300,
    parameter int unsigned CANCEL_ACTIVE  = 600,
    parameter int unsigned BLANK_MAX      = 400
) (
    input wire logic              i_clk_sys,
    input wire logic              i_arst_n,
    input wire logic              i_hw_reset_in_n,
    input wire logic              o_core_reset,
    input wire logic              o_blank,
    input wire logic              o_ready,
    input wire logic [NVM_DW-1:0] o_id0,
    input wire logic [NVM_DW-1:0] o_settings
);
    logic [15:0] low_q;
    logic [15:0] low_d;
    logic [15:0] high_q;
    logic [15:0] high_d;

    // Run lengths of the raw pin; they saturate so a long idle never wraps.
    always_comb begin
        low_d  = i_hw_reset_in_n ? 16'h0 : low_q + {15'h0, low_q != 16'hffff};
        high_d = i_hw_reset_in_n ? high_q + {15'h0, high_q != 16'hffff} : 16'h0;
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            low_q  <= 16'h0;
            high_q <= 16'h0;
        end else begin
            low_q  <= low_d;
            high_q <= high_d;
        end
    end

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);

    chk_spike_rejected: assert property (
        $rose(o_core_reset) && $past(i_arst_n) |-> low_q >= 16'(REJECT_CYC)
    ) else $error("core reset rose after a short low pulse");
    chk_long_pulse: assert property (low_q > 16'(ACCEPT_CYC) |-> o_core_reset)
        else $error("long low pulse did not reset the core");
    chk_glitch_ignored: assert property (
        o_core_reset && high_q < 16'd250 |=> !o_ready
    ) else $error("short high glitch ended the reset");
    chk_blank_in_reset: assert property (o_core_reset |-> o_blank)
        else $error("display not blanked during reset");
    chk_ready_clean: assert property (
        $rose(o_ready) |-> !o_core_reset && !o_blank
    ) else $error("ready rose while reset or blank still high");
    chk_load_stable: assert property (
        o_ready && $past(o_ready) |-> $stable(o_id0) && $stable(o_settings)
    ) else $error("loaded settings changed while ready");
    chk_cancel_bound: assert property (
        high_q == 16'(280 + CANCEL_ACTIVE + BLANK_MAX) |-> o_ready
    ) else $error("reset cancel took too long");
    chk_ready_early: assert property ($rose(o_ready) |-> high_q >= CANCEL_STANDBY)
        else $error("ready rose before the cancel time");
endmodule

bind display_reset_sequencer rst_seq_props #(
    .CANCEL_STANDBY(CANCEL_STANDBY),
    .CANCEL_ACTIVE (CANCEL_ACTIVE),
    .BLANK_MAX     (BLANK_MAX)
) chk (
    .i_clk_sys      (i_clk_sys),
    .i_arst_n       (i_arst_n),
    .i_hw_reset_in_n(i_hw_reset_in_n),
    .o_core_reset   (o_core_reset),
    .o_blank        (o_blank),
    .o_ready        (o_ready),
    .o_id0          (o_id0),
    .o_settings     (o_settings)
);

// >>> dv/test_display_reset_sequencer.sv
`timescale 1ns/1ns
module test_display_reset_sequencer
    import rst_seq_pkg::*;
;
    localparam int unsigned STB = 300;
    localparam int unsigned ACT = 600;
    typedef struct {int unsigned len; logic act; logic rst;} row_type;
    logic              clk;
    logic              arst_n;
    logic              pin;
    logic              act;
    logic              we;
    logic [NVM_AW-1:0] wa;
    logic [NVM_DW-1:0] wd;
    logic              core_rst;
    logic              blank;
    logic              ready;
    logic [NVM_DW-1:0] id0, id1, id2, lvl, cfg;
    logic              seen_rst;
    logic              seen_blank;
    logic              clr_seen;
    int                mismatches;
    int                checks;
    row_type rows[5] = '{'{500, 1'b0, 1'b1}, '{100, 1'b0, 1'b0}, '{240, 1'b0, 1'b0},
                         '{500, 1'b1, 1'b1}, '{900, 1'b1, 1'b1}};

    display_reset_sequencer #(.CANCEL_STANDBY(STB), .CANCEL_ACTIVE(ACT), .BLANK_MAX(400)) dut (
        .i_clk_sys(clk), .i_arst_n(arst_n), .i_hw_reset_in_n(pin), .i_display_active(act),
        .i_prog_we(we), .i_prog_addr(wa), .i_prog_data(wd), .o_core_reset(core_rst),
        .o_blank(blank), .o_ready(ready), .o_id0(id0), .o_id1(id1), .o_id2(id2),
        .o_common_electrode_level(lvl), .o_settings(cfg));
    reset_host host (.i_clk_sys(clk), .o_hw_reset_in_n(pin));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Only this process drives the seen flags; the stimulus asks for a clear.
    always @(posedge clk) begin
        if (clr_seen) begin
            seen_rst   <= 1'b0;
            seen_blank <= 1'b0;
        end else begin
            if (core_rst === 1'b1) seen_rst <= 1'b1;
            if (blank === 1'b1) seen_blank <= 1'b1;
        end
    end

    task automatic check_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected bit at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_set(input logic [39:0] got, input logic [39:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected settings at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_ready(output int n);
        n = 0;
        while (ready !== 1'b1 && n < 4000) begin
            @(posedge clk);
            #2 n++;
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        int n;
        int lim;
        arst_n = 1'b0;
        act = 1'b0;
        we = 1'b0;
        wa = '0;
        wd = '0;
        clr_seen = 1'b1;
        // The store keeps its words through reset, so it is filled while reset is held.
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            #1 we = 1'b1;
            wa = k[NVM_AW-1:0];
            wd = 8'ha0 + k[7:0];
        end
        @(posedge clk);
        #1 we = 1'b0;
        repeat (2) @(posedge clk);
        #1 check_bit(core_rst & blank & ~ready, 1'b1);
        check_set({id0, id1, id2, lvl, cfg}, {5{CFG_DEFAULT}});
        arst_n = 1'b1;
        wait_ready(n);
        check_bit(ready, 1'b1);
        check_set({id0, id1, id2, lvl, cfg}, 40'ha0a1a2a3a4);
        // Rows of pulse length, display mode and whether a reset must follow.
        foreach (rows[r]) begin
            act = rows[r].act;
            lim = rows[r].act ? ACT : STB;
            clr_seen = 1'b1;
            @(posedge clk);
            #1 clr_seen = 1'b0;
            host.pulse(rows[r].len, 0);
            wait_ready(n);
            check_bit(ready, 1'b1);
            check_bit(seen_rst, rows[r].rst);
            check_bit(seen_blank, rows[r].rst);
            // Ready follows the filtered release: two sync stages plus the reject window.
            if (rows[r].rst) check_bit(n >= lim && n <= lim + REJECT_CYC + 8, 1'b1);
            check_set({id0, id1, id2, lvl, cfg}, 40'ha0a1a2a3a4);
        end
        // A 2 us high glitch inside a valid reset must neither end nor restart it.
        act = 1'b0;
        host.pulse(500, 100);
        #1 check_bit(core_rst & ~ready, 1'b1);
        host.pulse(500, 0);
        wait_ready(n);
        check_bit(ready, 1'b1);
        check_bit(n >= STB && n <= STB + REJECT_CYC + 8, 1'b1);
        // An asynchronous reset in mid-run restores defaults, then reloads the store.
        @(posedge clk);
        #1 arst_n = 1'b0;
        #1 check_bit(core_rst & blank & ~ready, 1'b1);
        check_set({id0, id1, id2, lvl, cfg}, {5{CFG_DEFAULT}});
        repeat (2) @(posedge clk);
        #1 arst_n = 1'b1;
        wait_ready(n);
        check_bit(ready, 1'b1);
        check_set({id0, id1, id2, lvl, cfg}, 40'ha0a1a2a3a4);
        tally_and_finish;
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        tally_and_finish;
    end
endmodule

// >>> rtl/display_reset_sequencer.sv
`timescale 1ns/1ns
// Operation
// RULE1: Host holds reset low at least 10us.
// RULE2: Reject under 5us, reset beyond 9us.
// RULE3: Short high glitches within reset are ignored.
// RULE4: Reload ids, level, settings from NVM.
// RULE5: Cancel done in 5ms standby, 120ms active; code starts the active timer only after the BLANK_MAX wait, near 240ms.
// RULE6: Blank during reset, then restore defaults.
// RULE7: Host waits 5ms before any command.
// RULE8: Host waits 120ms before leaving standby.
module display_reset_sequencer
    import rst_seq_pkg::*;
#(
    parameter int unsigned CANCEL_STANDBY = CANCEL_STANDBY_CYC,
    parameter int unsigned CANCEL_ACTIVE  = CANCEL_ACTIVE_CYC,
    parameter int unsigned BLANK_MAX      = BLANK_MAX_CYC
) (
    // Clock and reset.
    input  wire logic              i_clk_sys,
    input  wire logic              i_arst_n,
    // Reset pin from the host.
    input  wire logic              i_hw_reset_in_n,
    // Display state from the controller core.
    input  wire logic              i_display_active,
    // Nonvolatile store programming.
    input  wire logic              i_prog_we,
    input  wire logic [NVM_AW-1:0] i_prog_addr,
    input  wire logic [NVM_DW-1:0] i_prog_data,
    // Sequencer status.
    output logic                   o_core_reset,
    output logic                   o_blank,
    output logic                   o_ready,
    // Loaded settings.
    output logic [NVM_DW-1:0]      o_id0,
    output logic [NVM_DW-1:0]      o_id1,
    output logic [NVM_DW-1:0]      o_id2,
    output logic [NVM_DW-1:0]      o_common_electrode_level,
    output logic [NVM_DW-1:0]      o_settings
);

    localparam logic [CNT_W-1:0] REJECT = CNT_W'(REJECT_CYC);
    localparam logic [CNT_W-1:0] ACCEPT = CNT_W'(ACCEPT_CYC);

    logic rst_meta_q;
    logic rst_n_q;
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    logic pin_meta_q;
    logic pin_q;
    always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pin_meta_q <= 1'b1;
            pin_q      <= 1'b1;
        end else begin
            pin_meta_q <= i_hw_reset_in_n;
            pin_q      <= pin_meta_q;
        end
    end

    // The filtered level changes only after the pin has held its new level
    // longer than the reject window, so a spike either way is dropped.
    logic             filt_q;
    logic             filt_d;
    logic [CNT_W-1:0] flt_cnt_q;
    logic [CNT_W-1:0] flt_cnt_d;
    always_comb begin
        filt_d    = filt_q;
        flt_cnt_d = '0;
        if (pin_q != filt_q) begin
            flt_cnt_d = flt_cnt_q + CNT_W'(1);
            if (flt_cnt_q >= REJECT) begin // see RULE2, see RULE3
                filt_d    = pin_q;
                flt_cnt_d = '0;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            filt_q    <= 1'b1;
            flt_cnt_q <= '0;
        end else begin
            filt_q    <= filt_d;
            flt_cnt_q <= flt_cnt_d;
        end
    end

    // Sequencer. A low pulse between the two windows starts a reset; the
    // full 9us figure is always covered because the filter fires at 5us.
    seq_state_type     st_q;
    seq_state_type     st_d;
    logic [CNT_W-1:0]  cnt_q;
    logic [CNT_W-1:0]  cnt_d;
    logic              from_active_q;
    logic              from_active_d;
    logic [NVM_AW-1:0] addr_q;
    logic [NVM_AW-1:0] addr_d;
    logic              rd_vld_q;
    logic              rd_vld_d;
    logic [NVM_AW-1:0] rd_addr_q;
    logic [NVM_AW-1:0] rd_addr_d;
    logic [NVM_DW-1:0] nvm_data;
    logic [NVM_DW-1:0] cfg_q [NVM_WORDS];
    logic [NVM_DW-1:0] cfg_d [NVM_WORDS];
    logic              core_rst_q;
    logic              core_rst_d;
    logic              blank_q;
    logic              blank_d;
    logic              ready_q;
    logic              ready_d;
    logic [CNT_W-1:0]  cancel_lim;

    assign cancel_lim = from_active_q ? CNT_W'(CANCEL_ACTIVE) : CNT_W'(CANCEL_STANDBY);

    always_comb begin
        st_d          = st_q;
        cnt_d         = cnt_q;
        from_active_d = from_active_q;
        addr_d        = addr_q;
        rd_vld_d      = 1'b0;
        rd_addr_d     = addr_q;
        cfg_d         = cfg_q;
        core_rst_d    = core_rst_q;
        blank_d       = blank_q;
        ready_d       = ready_q;
        case (st_q)
            ST_RUN: begin
                if (!filt_q) begin
                    from_active_d = i_display_active;
                    core_rst_d    = 1'b1;
                    blank_d       = 1'b1; // see RULE6
                    ready_d       = 1'b0;
                    cnt_d         = '0;
                    st_d          = i_display_active ? ST_BLANK : ST_HELD;
                end
            end
            ST_BLANK: begin
                // The ST_BLANK wait from the active state always runs the full BLANK_MAX cycles.
                cnt_d = cnt_q + CNT_W'(1);
                if (cnt_q >= CNT_W'(BLANK_MAX) - CNT_W'(1)) begin // see RULE6
                    st_d = ST_HELD;
                end
            end
            ST_HELD: begin
                // Defaults are restored while held; loading starts on release, or at once if release came during ST_BLANK.
                for (int i = 0; i < NVM_WORDS; i++) begin
                    cfg_d[i] = CFG_DEFAULT; // see RULE6
                end
                if (filt_q) begin
                    addr_d = '0;
                    cnt_d  = '0;
                    st_d   = ST_LOAD;
                end
            end
            ST_LOAD: begin
                cnt_d    = cnt_q + CNT_W'(1);
                rd_vld_d = 1'b1;
                if (addr_q == NVM_LAST) begin
                    st_d = ST_SETTLE;
                end else begin
                    addr_d = addr_q + NVM_AW'(1);
                end
            end
            ST_SETTLE: begin
                // The timer runs from release or the end of ST_BLANK, whichever is later, so loading counts toward it.
                cnt_d = cnt_q + CNT_W'(1);
                if (cnt_q >= cancel_lim - CNT_W'(1)) begin // see RULE5
                    core_rst_d = 1'b0;
                    blank_d    = 1'b0;
                    ready_d    = 1'b1;
                    st_d       = ST_RUN;
                end
            end
            default: begin
                st_d = ST_RUN;
            end
        endcase
        if (rd_vld_q) begin
            cfg_d[rd_addr_q] = nvm_data; // see RULE4
        end
        if (!filt_q && st_q != ST_RUN && st_q != ST_BLANK) begin
            // A new reset during cancel starts over from ST_HELD, skipping the ST_BLANK wait.
            st_d       = ST_HELD;
            core_rst_d = 1'b1;
            blank_d    = 1'b1;
            ready_d    = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q          <= ST_HELD;
            cnt_q         <= '0;
            from_active_q <= 1'b0;
            addr_q        <= '0;
            rd_vld_q      <= 1'b0;
            rd_addr_q     <= '0;
            core_rst_q    <= 1'b1;
            blank_q       <= 1'b1;
            ready_q       <= 1'b0;
            for (int i = 0; i < NVM_WORDS; i++) begin
                cfg_q[i] <= CFG_DEFAULT;
            end
        end else begin
            st_q          <= st_d;
            cnt_q         <= cnt_d;
            from_active_q <= from_active_d;
            addr_q        <= addr_d;
            rd_vld_q      <= rd_vld_d;
            rd_addr_q     <= rd_addr_d;
            core_rst_q    <= core_rst_d;
            blank_q       <= blank_d;
            ready_q       <= ready_d;
            cfg_q         <= cfg_d;
        end
    end

    nvm_store u_nvm (
        .i_clk_sys   (i_clk_sys),
        .i_addr      (addr_q),
        .o_data      (nvm_data),
        .i_prog_we   (i_prog_we),
        .i_prog_addr (i_prog_addr),
        .i_prog_data (i_prog_data)
    );

    assign o_core_reset             = core_rst_q;
    assign o_blank                  = blank_q;
    assign o_ready                  = ready_q;
    assign o_id0                    = cfg_q[0];
    assign o_id1                    = cfg_q[1];
    assign o_id2                    = cfg_q[NVM_ID_LAST];
    assign o_common_electrode_level = cfg_q[NVM_LEVEL_ADR];
    assign o_settings               = cfg_q[NVM_LEVEL_ADR + NVM_AW'(1)];

endmodule

// >>> rtl/nvm_store.sv
`timescale 1ns/1ns
module nvm_store
    import rst_seq_pkg::*;
(
    // Clock.
    input  wire logic              i_clk_sys,
    // Read port.
    input  wire logic [NVM_AW-1:0] i_addr,
    output logic      [NVM_DW-1:0] o_data,
    // Factory programming port.
    input  wire logic              i_prog_we,
    input  wire logic [NVM_AW-1:0] i_prog_addr,
    input  wire logic [NVM_DW-1:0] i_prog_data
);

    logic [NVM_DW-1:0] mem [NVM_WORDS];

    always_ff @(posedge i_clk_sys) begin
        if (i_prog_we) begin
            mem[i_prog_addr] <= i_prog_data;
        end
        o_data <= mem[i_addr];
    end

endmodule

// >>> rtl/rst_seq_pkg.sv
package rst_seq_pkg;

    localparam int unsigned CLK_MHZ             = 50;
    // Reset line filtering thresholds, in microseconds.
    localparam int unsigned REJECT_US           = 5;
    localparam int unsigned ACCEPT_US           = 9;
    localparam int unsigned RESET_LOW_MIN_US    = 10;
    // Reset-cancel limits, in milliseconds.
    localparam int unsigned CANCEL_STANDBY_MS   = 5;
    localparam int unsigned CANCEL_ACTIVE_MS    = 120;
    localparam int unsigned BLANK_MAX_MS        = 120;

    // Each count is an exact product of its time and CLK_MHZ; none is rounded.
    localparam int unsigned REJECT_CYC  = REJECT_US * CLK_MHZ;
    localparam int unsigned ACCEPT_CYC  = ACCEPT_US * CLK_MHZ;
    localparam int unsigned CANCEL_STANDBY_CYC = CANCEL_STANDBY_MS * 1000 * CLK_MHZ;
    localparam int unsigned CANCEL_ACTIVE_CYC  = CANCEL_ACTIVE_MS * 1000 * CLK_MHZ;
    localparam int unsigned BLANK_MAX_CYC      = BLANK_MAX_MS * 1000 * CLK_MHZ;

    localparam int unsigned CNT_W      = 24;
    localparam int unsigned NVM_AW     = 4;
    localparam int unsigned NVM_WORDS  = 16;
    localparam int unsigned NVM_DW     = 8;
    localparam logic [NVM_AW-1:0] NVM_ID_LAST   = 4'h2;
    localparam logic [NVM_AW-1:0] NVM_LEVEL_ADR = 4'h3;
    localparam logic [NVM_AW-1:0] NVM_LAST      = 4'hf;
    localparam logic [NVM_DW-1:0] CFG_DEFAULT   = 8'h00;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_BLANK,
        ST_HELD,
        ST_LOAD,
        ST_SETTLE
    } seq_state_type;

endpackage
